// ===== rtl/csoc_pkg.sv
// csoc_pkg: shared constants and types for offset calibration and channel 4 regulation
package csoc_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_CH      = 5;    // ch1, ch2, ch3, ch4l, ch4h
    localparam int CH_W        = 3;
    localparam int OFS_W       = 6;
    localparam int DAC_W       = 8;
    localparam int NEG_W       = 4;
    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [DAC_W-1:0] CAL_BIAS_CODE = 8'h1A;
    localparam logic signed [OFS_W-1:0] OFS_MAX = 6'sh1F;   // +31
    localparam logic signed [OFS_W-1:0] OFS_MIN = -6'sh1F;  // -31
    localparam logic signed [OFS_W-1:0] OFS_RST = 6'sh00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 50;
    localparam int STEP_NS      = 2000;  // longest step time, 2.0 us
    localparam int RUN_US       = 62;    // longest run time
    localparam int STEP_CYC     = (STEP_NS * CLK_MHZ) / 1000;   // rounds down
    localparam int RUN_CYC      = RUN_US * CLK_MHZ;
    localparam int SETTLE_CYC   = 16;    // analog settle before sampling
    localparam int CNT_W        = 12;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic {CH4_STANDARD, CH4_DCDC} csoc_ch4_mode_t;

    typedef struct packed {
        logic            start;
        logic            stop;
        logic [CH_W-1:0] ch;
    } csoc_cmd_t;

    typedef struct packed {
        logic               busy;
        logic               done;
        logic               aborted;
        logic [CH_W-1:0]    ch;
        logic [OFS_W-1:0]   value;
    } csoc_stat_t;
endpackage

// ===== rtl/csoc_ofs_mem.sv
// csoc_ofs_mem: per-channel offset store with registered read
`timescale 1ns/1ns
module csoc_ofs_mem #(
    parameter int DEPTH = 5,
    parameter int AW    = 3,
    parameter int DW    = 6
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    // write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    // read port
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [DEPTH];

    // ------------------------------------------------------------
    // storage, cleared at reset
    // ------------------------------------------------------------
    for (genvar g = 0; g < DEPTH; g++) begin : g_word
        always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
                mem[g] <= '0;
            end else if (we_i && (waddr_i == AW'(g))) begin
                mem[g] <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
        end else if (raddr_i < AW'(DEPTH)) begin
            rdata_o <= mem[raddr_i];
        end else begin
            rdata_o <= '0;
        end
    end
endmodule

// ===== rtl/csoc_top.sv
// csoc_top: offset calibration sequencer and channel 4 two-point regulator
// How it works
// - on a start the threshold DAC of the addressed channel is forced to code 0x1A.
// - when a run completes the feedback compare output of that channel is held low until the next start.
// - each channel keeps its own offset, and a new run begins from that stored value.
// - a stop during a run aborts it and keeps the value reached at that moment.
// - the offset is signed and saturates at -31 and +31.
// - each adjustment step takes at most 2.0 us.
// - a full run ends within 62 us of its start.
// - a hard-wired two-point regulator drives the boost low-side gate from the two channel 4 comparators while no run is active.
// - a third channel 4 comparator reports negative current on its own output.
// - channel 4 works either as a standard channel or as the converter regulator.
// - in regulator mode the high and low sub-channels each act as a standard channel.
`timescale 1ns/1ns
module csoc_top
    import csoc_pkg::*;
#(
    parameter int NCH = csoc_pkg::NUM_CH
) (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        nrst_i,
    // microcore commands
    input  wire csoc_pkg::csoc_cmd_t         cmd_i,
    input  wire csoc_pkg::csoc_ch4_mode_t    ch4_mode_i,
    input  wire logic [csoc_pkg::NEG_W-1:0]  negative_threshold_code_i,
    // analog comparators
    input  wire logic [NCH-1:0]              cmp_raw_i,
    input  wire logic                        neg_cmp_raw_i,
    // analog controls
    output logic [csoc_pkg::DAC_W-1:0]       cal_dac_code_o,
    output logic                             cal_dac_force_o,
    output logic [csoc_pkg::OFS_W-1:0]       offset_trim_o,
    output logic [csoc_pkg::CH_W-1:0]        trim_ch_o,
    output logic [csoc_pkg::NEG_W-1:0]       neg_dac_code_o,
    // digital outputs
    output logic [NCH-1:0]                   channel_feedback_compare_o,
    output logic                             boost_lowside_gate_o,
    output logic                             negative_current_o,
    output csoc_pkg::csoc_stat_t             status_o
);
    import csoc_pkg::*;

    localparam int CH4L = 3;
    localparam int CH4H = 4;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [NCH-1:0] cmp_m;
    logic [NCH-1:0] cmp_s;
    logic           neg_m;
    logic           neg_s;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cmp_m <= '0;
            cmp_s <= '0;
            neg_m <= 1'b0;
            neg_s <= 1'b0;
        end else begin
            cmp_m <= cmp_raw_i;
            cmp_s <= cmp_m;
            neg_m <= neg_cmp_raw_i;
            neg_s <= neg_m;
        end
    end

    // ------------------------------------------------------------
    // offset store
    // ------------------------------------------------------------
    typedef enum logic [2:0] {S_IDLE, S_LOAD, S_WAIT, S_SETTLE, S_STEP} csoc_state_t;

    csoc_state_t             state;
    csoc_state_t             next_state;
    logic [CH_W-1:0]         ch;
    logic signed [OFS_W-1:0] ofs;
    logic signed [OFS_W-1:0] next_ofs;
    logic                    first_dir;
    logic                    have_dir;
    logic [CNT_W-1:0]        step_cnt;
    logic [CNT_W-1:0]        run_cnt;
    logic [OFS_W-1:0]        mem_rdata;
    logic                    mem_we;
    logic                    done;
    logic                    aborted;
    logic [NCH-1:0]          hold_low;

    csoc_ofs_mem #(.DEPTH(NCH), .AW(CH_W), .DW(OFS_W)) u_mem (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .we_i    (mem_we),
        .waddr_i (ch),
        .wdata_i (ofs),
        .raddr_i (ch),
        .rdata_o (mem_rdata)
    );

    // ------------------------------------------------------------
    // sequencer decode
    // ------------------------------------------------------------
    wire       ch_ok     = cmd_i.ch < CH_W'(NCH);
    wire       start_ok  = cmd_i.start && !cmd_i.stop && ch_ok && (state == S_IDLE);
    wire       stop_req  = cmd_i.stop && (state != S_IDLE);
    wire       cmp_now   = cmp_s[ch];
    wire       at_bound  = cmp_now ? (ofs == OFS_MIN) : (ofs == OFS_MAX);
    wire       flipped   = have_dir && (cmp_now != first_dir);
    wire       step_end  = step_cnt == CNT_W'(STEP_CYC - 1);
    wire       run_end   = run_cnt >= CNT_W'(RUN_CYC - STEP_CYC);
    wire       finish    = (state == S_STEP) && (flipped || at_bound || run_end);
    wire signed [OFS_W-1:0] ofs_up = ofs + 6'sh01;
    wire signed [OFS_W-1:0] ofs_dn = ofs - 6'sh01;

    always_comb begin
        next_state = state;
        next_ofs   = ofs;
        case (state)
            S_IDLE:   if (start_ok) next_state = S_LOAD;
            S_LOAD:   next_state = S_WAIT;
            S_WAIT:   begin
                next_ofs   = mem_rdata;
                next_state = S_SETTLE;
            end
            S_SETTLE: if (step_cnt == CNT_W'(SETTLE_CYC - 1)) next_state = S_STEP;
            S_STEP:   begin
                if (finish) begin
                    next_state = S_IDLE;
                end else if (step_end) begin
                    next_ofs = cmp_now ? ofs_dn : ofs_up;
                end
            end
            default:  next_state = S_IDLE;
        endcase
        if (stop_req) begin
            next_state = S_IDLE;
            next_ofs   = ofs;
        end
    end

    assign mem_we = (finish || stop_req) && (state inside {S_SETTLE, S_STEP});

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state <= S_IDLE;
            ofs   <= OFS_RST;
            ch    <= '0;
        end else begin
            state <= next_state;
            ofs   <= next_ofs;
            if (start_ok) ch <= cmd_i.ch;
        end
    end

    // step and run counters, first comparator direction
    always_ff @(posedge clk_i) begin
        if (!nrst_i || state == S_IDLE || state == S_LOAD || state == S_WAIT) begin
            step_cnt  <= '0;
            run_cnt   <= '0;
            have_dir  <= 1'b0;
            first_dir <= 1'b0;
        end else begin
            run_cnt <= run_cnt + CNT_W'(1);
            if (state == S_SETTLE && next_state == S_STEP) begin
                step_cnt <= '0;
            end else if (state == S_STEP && step_end) begin
                step_cnt <= '0;
                if (!have_dir) begin
                    have_dir  <= 1'b1;
                    first_dir <= cmp_now;
                end
            end else begin
                step_cnt <= step_cnt + CNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // calibration outputs and status
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cal_dac_code_o  <= '0;
            cal_dac_force_o <= 1'b0;
            offset_trim_o   <= '0;
            trim_ch_o       <= '0;
            done            <= 1'b0;
            aborted         <= 1'b0;
            hold_low        <= '0;
        end else begin
            cal_dac_force_o <= (next_state != S_IDLE);
            cal_dac_code_o  <= (next_state != S_IDLE) ? CAL_BIAS_CODE : '0;
            offset_trim_o   <= next_ofs;
            trim_ch_o       <= start_ok ? cmd_i.ch : ch;
            if (start_ok) begin
                done     <= 1'b0;
                aborted  <= 1'b0;
                hold_low <= '0;
            end else if (finish && !stop_req) begin
                done         <= 1'b1;
                hold_low[ch] <= 1'b1;
            end else if (stop_req) begin
                aborted <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // channel 4 two-point regulator and comparator outputs
    // ------------------------------------------------------------
    logic     gate_on;
    wire      dcdc      = (ch4_mode_i == CH4_DCDC);
    wire      reg_run   = dcdc && (state == S_IDLE);
    wire      next_gate = !cmp_s[CH4L] ? 1'b1 :
                          cmp_s[CH4H] ? 1'b0 : gate_on;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            gate_on                    <= 1'b0;
            boost_lowside_gate_o       <= 1'b0;
            negative_current_o         <= 1'b0;
            neg_dac_code_o             <= '0;
            channel_feedback_compare_o <= '0;
            status_o                   <= '0;
        end else begin
            gate_on                    <= reg_run ? next_gate : 1'b0;
            boost_lowside_gate_o       <= reg_run && next_gate;
            negative_current_o         <= dcdc && neg_s;
            neg_dac_code_o             <= negative_threshold_code_i;
            channel_feedback_compare_o <= cmp_s & ~hold_low;
            status_o.busy              <= (next_state != S_IDLE);
            status_o.done              <= done;
            status_o.aborted           <= aborted;
            status_o.ch                <= ch;
            status_o.value             <= ofs;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_bias_code_load: assert property (start_ok |=> ##1 cal_dac_code_o == 8'h1A)
        else $error("bias code not loaded");
    a_done_fbk_low: assert property (finish && !stop_req |=> ##1 !channel_feedback_compare_o[$past(ch, 2)])
        else $error("feedback not low after run");
    a_resume_stored: assert property (state == S_WAIT |=> ofs == $past(mem_rdata))
        else $error("run not resumed from stored value");
    a_stop_keeps: assert property (stop_req |=> state == S_IDLE && ofs == $past(ofs))
        else $error("stop did not keep value");
    a_ofs_bounds: assert property (ofs <= OFS_MAX && ofs >= OFS_MIN)
        else $error("offset out of range");
    a_step_single: assert property (state == S_STEP |=> (ofs - $past(ofs)) inside {6'sh00, 6'sh01, -6'sh01})
        else $error("offset step larger than one");
    a_step_time: assert property (state == S_STEP && step_cnt == '0 |-> ##[1:100] (state != S_STEP || step_end))
        else $error("step exceeds time");
    a_run_time: assert property (state == S_STEP |-> run_cnt <= CNT_W'(RUN_CYC))
        else $error("run exceeds time");
    a_gate_off_high: assert property (reg_run && cmp_s[CH4H] && cmp_s[CH4L] |=> !boost_lowside_gate_o)
        else $error("gate on above upper threshold");
    a_no_self_start: assert property (state == S_IDLE && !cmd_i.start |=> state == S_IDLE)
        else $error("run started without command");

    c_run_done:  cover property (finish && !stop_req);
    c_run_stop:  cover property (stop_req && state == S_STEP);
    c_sat_max:   cover property (ofs == OFS_MAX);
    c_gate_on:   cover property (boost_lowside_gate_o);
endmodule

// ===== tb/csoc_core_model.sv
// csoc_core_model: microcore side issuing calibration commands and negative threshold codes
`timescale 1ns/1ns
module csoc_core_model
    import csoc_pkg::*;
(
    // clock
    input  wire logic                        clk_i,
    // commands toward the block
    output csoc_pkg::csoc_cmd_t              cmd_o,
    output logic [csoc_pkg::NEG_W-1:0]       neg_code_o
);
    initial begin
        cmd_o      = '0;
        neg_code_o = '0;
    end
    // ------------------------------------------------------------
    // command tasks, called just after a rising edge
    // ------------------------------------------------------------
    // a run starts only when this task is called; gain is assumed at its maximum already
    task automatic start_run(input logic [CH_W-1:0] ch);
        cmd_o.ch    = ch;
        cmd_o.start = 1'b1;
        @(posedge clk_i);
        #2;
        cmd_o.start = 1'b0;
    endtask
    // stop is a one-cycle level, taken at any edge while a run is active
    task automatic stop_run();
        cmd_o.stop = 1'b1;
        @(posedge clk_i);
        #2;
        cmd_o.stop = 1'b0;
    endtask
    // threshold may change at any time
    task automatic set_neg(input logic [NEG_W-1:0] code);
        neg_code_o = code;
    endtask
endmodule

// ===== tb/csoc_top_tb.sv
// csoc_top_tb: self-checking bench for offset calibration and channel 4 regulation
`timescale 1ns/1ns
module csoc_top_tb;
    import csoc_pkg::*;
    logic                 clk_i;
    logic                 nrst_i;
    csoc_cmd_t            cmd;
    csoc_ch4_mode_t       mode;
    logic [NEG_W-1:0]     neg_code;
    logic [NUM_CH-1:0]    cmp;
    logic                 neg_cmp;
    logic [DAC_W-1:0]     dac_code;
    logic                 dac_force;
    logic [OFS_W-1:0]     trim;
    logic [CH_W-1:0]      tch;
    logic [NEG_W-1:0]     neg_dac;
    logic [NUM_CH-1:0]    fbk;
    logic                 gate;
    logic                 neg_cur;
    csoc_stat_t           st;
    int                   miscompares;
    int                   num_checks;
    int                   n;
    logic [OFS_W-1:0]     v;
    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    csoc_core_model core (.clk_i(clk_i), .cmd_o(cmd), .neg_code_o(neg_code));
    csoc_top uut (
        .clk_i(clk_i), .nrst_i(nrst_i), .cmd_i(cmd), .ch4_mode_i(mode),
        .negative_threshold_code_i(neg_code), .cmp_raw_i(cmp), .neg_cmp_raw_i(neg_cmp),
        .cal_dac_code_o(dac_code), .cal_dac_force_o(dac_force), .offset_trim_o(trim),
        .trim_ch_o(tch), .neg_dac_code_o(neg_dac), .channel_feedback_compare_o(fbk),
        .boost_lowside_gate_o(gate), .negative_current_o(neg_cur), .status_o(st));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #2;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wait_idle(input int lim);
        n = 0;
        while (st.busy !== 1'b0 && n < lim) begin
            tick(1);
            n++;
        end
        if (n >= lim) begin
            miscompares++;
            $display("wrong value busy_timeout expected 0 seen 1");
            end_of_test();
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_saturate();
        cmp = '0;
        core.start_run(3'h0);
        tick(1);
        chk("dac_code", 8'h1A, dac_code);
        chk("dac_force", 8'h01, {7'h00, dac_force});
        wait_idle(RUN_CYC + 50);
        chk("run_in_time", 8'h01, {7'h00, n <= RUN_CYC});
        tick(2);
        chk("done", 8'h01, {7'h00, st.done});
        v = st.value;
        // the run limit stops the climb from zero a few steps short of the bound
        chk("run_cut", 8'((RUN_CYC - STEP_CYC - SETTLE_CYC) / STEP_CYC), {2'h0, v});
        cmp[0] = 1'b1;
        tick(5);
        chk("fbk_low", 8'h00, {7'h00, fbk[0]});
        cmp[0] = 1'b0;
        core.start_run(3'h0);
        tick(3);
        chk("resume_value", {2'h0, v}, {2'h0, trim});
        wait_idle(RUN_CYC + 50);
        chk("step_time", 8'h01, {7'h00, n <= (32 - $signed(v)) * STEP_CYC + 40});
        tick(2);
        chk("saturated", 8'h1F, {2'h0, st.value});
    endtask
    task automatic t_abort();
        core.start_run(3'h1);
        tick(3);
        chk("own_start", 8'h00, {2'h0, trim});
        chk("trim_ch", 8'h01, {5'h00, tch});
        tick(SETTLE_CYC + 249);
        v = trim;
        chk("two_steps", 8'h01, {7'h00, $signed(v) >= 2});
        core.stop_run();
        tick(2);
        chk("aborted", 8'h01, {7'h00, st.aborted});
        chk("kept_value", {2'h0, v}, {2'h0, st.value});
        core.start_run(3'h1);
        tick(3);
        chk("own_store", {2'h0, v}, {2'h0, trim});
        core.stop_run();
        wait_idle(10);
    endtask
    task automatic t_flip();
        core.start_run(3'h2);
        tick(3);
        chk("ch2_start", 8'h00, {2'h0, trim});
        n = 0;
        while (trim === '0 && n < 300) begin
            tick(1);
            n++;
        end
        if (n >= 300) begin
            miscompares++;
            $display("wrong value trim_timeout expected 1 seen 0");
            end_of_test();
        end
        cmp[2] = 1'b1;
        wait_idle(400);
        // two synchroniser stages, then one edge that registers both the decision and busy
        chk("flip_ends", 8'h01, {7'h00, n <= 4});
        tick(2);
        chk("flip_value", 8'h01, {2'h0, st.value});
        core.start_run(3'h5);
        tick(2);
        chk("bad_ch", 8'h00, {7'h00, st.busy});
    endtask
    task automatic t_regulate();
        mode = CH4_DCDC;
        cmp[4:3] = 2'b00;
        tick(5);
        chk("gate_on", 8'h01, {7'h00, gate});
        cmp[4:3] = 2'b01;
        tick(5);
        chk("gate_hold", 8'h01, {7'h00, gate});
        chk("sub_fbk", 8'h01, {6'h00, fbk[4:3]});
        cmp[4:3] = 2'b11;
        tick(5);
        chk("gate_off", 8'h00, {7'h00, gate});
        neg_cmp = 1'b1;
        tick(5);
        chk("neg_cur", 8'h01, {7'h00, neg_cur});
        mode = CH4_STANDARD;
        cmp[4:3] = 2'b00;
        tick(5);
        chk("gate_std", 8'h00, {7'h00, gate});
        chk("neg_std", 8'h00, {7'h00, neg_cur});
        for (int c = 0; c < 16; c++) begin
            core.set_neg(c[NEG_W-1:0]);
            tick(1);
            chk("neg_dac", 8'(c), {4'h0, neg_dac});
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        miscompares = 0;
        num_checks  = 0;
        nrst_i      = 1'b0;
        mode        = CH4_STANDARD;
        cmp         = '0;
        neg_cmp     = 1'b0;
        tick(4);
        nrst_i = 1'b1;
        tick(1);
        chk("reset_status", 8'h00, {7'h00, st.busy | gate | dac_force});
        t_saturate();
        t_abort();
        t_flip();
        t_regulate();
        end_of_test();
    end
endmodule
